// >>> hw/xcvr_sync.sv
// package of shared constants and types, plus the two-stage pin synchroniser
`timescale 1ns/1ps
`default_nettype none

package xcvr_pkg;
   localparam int DATA_W = 8;
   localparam int SYNC_STAGES = 2;
   localparam logic [DATA_W-1:0] STORE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] OUT_RESET = 8'h00;
   localparam logic [DATA_W-1:0] OE_OFF = 8'h00;
   localparam logic [DATA_W-1:0] OE_ON = 8'hFF;

   // control pins, carried together
   typedef struct packed {
      logic oe_n;
      logic dir;
      logic a2b_src;
      logic b2a_src;
   } ctrl_t;
   localparam int CTRL_W = $bits(ctrl_t);
   // pins at rest: outputs disabled, everything else low
   localparam ctrl_t CTRL_IDLE = '{1'b1, 1'b0, 1'b0, 1'b0};
endpackage

module xcvr_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // asynchronous input and its synchronised copy
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         // each pin starts at its idle level, so no false activity follows reset
         meta_r <= RESET_VAL;
         o_sync <= RESET_VAL;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule // xcvr_sync

`default_nettype wire

// >>> hw/octal_registered_bus_transceiver.sv
// eight-bit registered bus transceiver between ports a and b
`timescale 1ns/1ps
`default_nettype none

module octal_registered_bus_transceiver
   import xcvr_pkg::*;
#(
   parameter int W = DATA_W
) (
   // system clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // control pins
   input wire logic i_oe_n,
   input wire logic i_dir,
   input wire logic i_a2b_src,
   input wire logic i_b2a_src,
   // transfer clock pins
   input wire logic i_a2b_xfer_clk,
   input wire logic i_b2a_xfer_clk,
   // port a pins
   input wire logic [W-1:0] i_a,
   output logic [W-1:0] o_a,
   output logic [W-1:0] o_a_oe,
   // port b pins
   input wire logic [W-1:0] i_b,
   output logic [W-1:0] o_b,
   output logic [W-1:0] o_b_oe,
   // stored words for observation
   output logic [W-1:0] o_a_side_stored_word,
   output logic [W-1:0] o_b_side_stored_word
);
   localparam int SYNC_W = CTRL_W + 2 + 2 * W;
   // synchroniser starts with the enable pin idle, so no port drives right after reset
   localparam logic [SYNC_W-1:0] SYNC_RESET = {CTRL_IDLE, {(SYNC_W-CTRL_W){1'b0}}};

   logic [SYNC_W-1:0] sync_bus;
   ctrl_t ctrl_s;
   logic a_clk_s;
   logic b_clk_s;
   logic [W-1:0] a_s;
   logic [W-1:0] b_s;
   logic a_clk_d_r;
   logic b_clk_d_r;
   logic a_rise;
   logic b_rise;
   logic [W-1:0] a_word_r;
   logic [W-1:0] b_word_r;
   logic [W-1:0] a_word_nxt;
   logic [W-1:0] b_word_nxt;
   logic [W-1:0] a_out_nxt;
   logic [W-1:0] b_out_nxt;

   // every pin, clocks included, passes two flops before use
   xcvr_sync #(
      .WIDTH(SYNC_W),
      .RESET_VAL(SYNC_RESET)
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_async({i_oe_n, i_dir, i_a2b_src, i_b2a_src, i_a2b_xfer_clk, i_b2a_xfer_clk, i_a, i_b}),
      .o_sync(sync_bus)
   );

   assign ctrl_s = ctrl_t'(sync_bus[SYNC_W-1 -: CTRL_W]);
   assign a_clk_s = sync_bus[2*W+1];
   assign b_clk_s = sync_bus[2*W];
   assign a_s = sync_bus[2*W-1 -: W];
   assign b_s = sync_bus[W-1:0];

   // edge detect on the synchronised transfer clocks
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         a_clk_d_r <= 1'b0;
         b_clk_d_r <= 1'b0;
      end else begin
         a_clk_d_r <= a_clk_s;
         b_clk_d_r <= b_clk_s;
      end
   end

   assign a_rise = a_clk_s & ~a_clk_d_r;
   assign b_rise = b_clk_s & ~b_clk_d_r;

   // data and clock share the same synchroniser depth, so setup is kept
   always_comb begin
      a_word_nxt = a_rise ? a_s : a_word_r;
      b_word_nxt = b_rise ? b_s : b_word_r;
   end

   // stored words; reset is for simulation tidiness only
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         a_word_r <= STORE_RESET;
         b_word_r <= STORE_RESET;
      end else begin
         a_word_r <= a_word_nxt;
         b_word_r <= b_word_nxt;
      end
   end

   // output data taken from next stored value so a new load shows at once
   always_comb begin
      b_out_nxt = ctrl_s.a2b_src ? a_word_nxt : a_s;
      a_out_nxt = ctrl_s.b2a_src ? b_word_nxt : b_s;
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_a <= OUT_RESET;
         o_b <= OUT_RESET;
      end else begin
         o_a <= a_out_nxt;
         o_b <= b_out_nxt;
      end
   end

   // drive enables; never both on, so the buses cannot fight
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_a_oe <= OE_OFF;
         o_b_oe <= OE_OFF;
      end else if (ctrl_s.oe_n) begin
         o_a_oe <= OE_OFF;
         o_b_oe <= OE_OFF;
      end else if (ctrl_s.dir) begin
         o_a_oe <= OE_OFF;
         o_b_oe <= OE_ON;
      end else begin
         o_a_oe <= OE_ON;
         o_b_oe <= OE_OFF;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_a_side_stored_word <= STORE_RESET;
         o_b_side_stored_word <= STORE_RESET;
      end else begin
         o_a_side_stored_word <= a_word_nxt;
         o_b_side_stored_word <= b_word_nxt;
      end
   end

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_reset);

   a_hiz_when_off: assert property (
      ctrl_s.oe_n |=> (o_a_oe == OE_OFF && o_b_oe == OE_OFF))
      else $error("port driven while output enable is high");
   a_one_port_drives: assert property (
      !ctrl_s.oe_n |=> ((o_a_oe == OE_ON) != (o_b_oe == OE_ON)))
      else $error("not exactly one port driving");
   a_b_port_drives: assert property (
      (!ctrl_s.oe_n && ctrl_s.dir) |=> (o_b_oe == OE_ON && o_a_oe == OE_OFF))
      else $error("direction high did not drive port b only");
   a_a_port_drives: assert property (
      (!ctrl_s.oe_n && !ctrl_s.dir) |=> (o_a_oe == OE_ON && o_b_oe == OE_OFF))
      else $error("direction low did not drive port a only");
   a_a_word_loads: assert property (a_rise |=> a_word_r == $past(a_s))
      else $error("a-side word not loaded on clock edge");
   a_load_while_off: assert property ((b_rise && ctrl_s.oe_n) |=> b_word_r == $past(b_s))
      else $error("b-side word not loaded while outputs off");
   a_a_shows_word: assert property (
      (!ctrl_s.oe_n && !ctrl_s.dir && ctrl_s.b2a_src) |=> o_a == b_word_r)
      else $error("port a not showing b-side stored word");
   a_a_follows_b: assert property (
      (ctrl_s.b2a_src == 1'b0 && !ctrl_s.dir) |=> o_a == $past(b_s))
      else $error("port a not following port b");
   a_b_follows_a: assert property ((!ctrl_s.a2b_src && ctrl_s.dir) |=> o_b == $past(a_s))
      else $error("port b not following port a");
   a_b_shows_word: assert property (
      (ctrl_s.a2b_src && ctrl_s.dir) |=> o_b == a_word_r)
      else $error("port b not showing a-side stored word");
   a_words_hold: assert property (
      (!a_rise && !b_rise) |=> ($stable(a_word_r) && $stable(b_word_r)))
      else $error("stored word changed without its clock edge");

   // enables switch as whole ports and never overlap
   a_never_both_drive: assert property (!(o_a_oe == OE_ON && o_b_oe == OE_ON))
      else $error("both ports driving at once");
   a_enables_whole: assert property (
      (o_a_oe == OE_ON || o_a_oe == OE_OFF) && (o_b_oe == OE_ON || o_b_oe == OE_OFF))
      else $error("port enable bits disagree");

   // storage captures and holds whatever the port roles are
   a_b_word_loads: assert property (b_rise |=> b_word_r == $past(b_s))
      else $error("b-side word not loaded on clock edge");
   a_a_load_off: assert property ((a_rise && ctrl_s.oe_n) |=> a_word_r == $past(a_s))
      else $error("a-side word not loaded while outputs off");
   a_a_load_input: assert property (
      (a_rise && !ctrl_s.oe_n && ctrl_s.dir) |=> a_word_r == $past(a_s))
      else $error("a-side word not loaded while port a is input");
   a_b_load_input: assert property (
      (b_rise && !ctrl_s.oe_n && !ctrl_s.dir) |=> b_word_r == $past(b_s))
      else $error("b-side word not loaded while port b is input");
   a_a_word_kept: assert property ((b_rise && !a_rise) |=> $stable(a_word_r))
      else $error("a-side word changed on b-side clock");
   a_b_word_kept: assert property ((a_rise && !b_rise) |=> $stable(b_word_r))
      else $error("b-side word changed on a-side clock");
   a_a_obs_word: assert property (a_rise |=> o_a_side_stored_word == $past(a_s))
      else $error("a-side stored word output not loaded");
   a_b_obs_word: assert property (b_rise |=> o_b_side_stored_word == $past(b_s))
      else $error("b-side stored word output not loaded");

   // data paths, a word loaded in the same cycle included
   a_fresh_to_a: assert property ((b_rise && ctrl_s.b2a_src) |=> o_a == $past(b_s))
      else $error("fresh b-side word did not reach port a");
   a_fresh_to_b: assert property ((a_rise && ctrl_s.a2b_src) |=> o_b == $past(a_s))
      else $error("fresh a-side word did not reach port b");
   a_a_keeps_word: assert property (
      (ctrl_s.b2a_src && !b_rise) |=> o_a == $past(b_word_r))
      else $error("port a left the b-side stored word");
   a_b_keeps_word: assert property (
      (ctrl_s.a2b_src && !a_rise) |=> o_b == $past(a_word_r))
      else $error("port b left the a-side stored word");
endmodule // octal_registered_bus_transceiver

`default_nettype wire

// >>> testbench/bus_far_end.sv
// far-side partner: drives its own data on each bit the device leaves undriven
`timescale 1ns/1ps
`default_nettype none
module bus_far_end
   import xcvr_pkg::*;
(
   // device side
   input wire logic [DATA_W-1:0] i_dev_d,
   input wire logic [DATA_W-1:0] i_dev_oe,
   // far-side data and resolved wire
   input wire logic [DATA_W-1:0] i_far_d,
   output logic [DATA_W-1:0] o_wire
);
   // the far end yields per bit, so there is never contention on the wire
   assign o_wire = (i_dev_oe & i_dev_d) | (~i_dev_oe & i_far_d);
endmodule // bus_far_end
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking testbench for the registered bus transceiver
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import xcvr_pkg::*;
   logic clk = 1'b0, rst = 1'b1, ca = 1'b0, cb = 1'b0;
   ctrl_t c = '{1'b1, 1'b0, 1'b0, 1'b0};
   logic [7:0] fa = 8'h00, fb = 8'h00, ia, ib, oa, ob, aoe, boe, qa, qb;
   int bad_count = 0, tests_run = 0;
   always #2.5 clk = ~clk;
   octal_registered_bus_transceiver dut (.i_sys_clk(clk), .i_reset(rst), .i_oe_n(c.oe_n),
      .i_dir(c.dir), .i_a2b_src(c.a2b_src), .i_b2a_src(c.b2a_src), .i_a2b_xfer_clk(ca),
      .i_b2a_xfer_clk(cb), .i_a(ia), .o_a(oa), .o_a_oe(aoe), .i_b(ib), .o_b(ob),
      .o_b_oe(boe), .o_a_side_stored_word(qa), .o_b_side_stored_word(qb));
   bus_far_end pa (.i_dev_d(oa), .i_dev_oe(aoe), .i_far_d(fa), .o_wire(ia));
   bus_far_end pb (.i_dev_d(ob), .i_dev_oe(boe), .i_far_d(fb), .o_wire(ib));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic gap(input int n);
      repeat (n) @(negedge clk);
   endtask
   // phases held well past the one-cycle minimum so no edge is missed
   task automatic pulse(input bit b_side);
      if (b_side) cb = 1'b1;
      else ca = 1'b1;
      gap(3);
      ca = 1'b0;
      cb = 1'b0;
      gap(6);
   endtask
   task automatic set(input ctrl_t v);
      c = v;
      gap(5);
   endtask
   task automatic t_after_reset;
      gap(1);
      chk("a_oe_rst", 8'h00, aoe);
      chk("b_oe_rst", 8'h00, boe);
      gap(1);
      chk("a_oe_rst", 8'h00, aoe);
      chk("b_oe_rst", 8'h00, boe);
      $display("test after reset done");
   endtask
   task automatic t_disabled;
      set('{1'b1, 1'b0, 1'b1, 1'b1});
      fa = 8'h3C;
      fb = 8'hA5;
      gap(2);
      pulse(1'b0);
      pulse(1'b1);
      chk("a_oe", 8'h00, aoe);
      chk("b_oe", 8'h00, boe);
      chk("a_word", 8'h3C, qa);
      chk("b_word", 8'hA5, qb);
      $display("test disabled done");
   endtask
   task automatic t_a_drives;
      set('{1'b0, 1'b0, 1'b0, 1'b0});
      chk("a_oe", 8'hFF, aoe);
      chk("b_oe", 8'h00, boe);
      fb = 8'h5A;
      gap(5);
      chk("a_live", 8'h5A, oa);
      pulse(1'b1);
      chk("b_word", 8'h5A, qb);
      chk("a_word", 8'h3C, qa);
      set('{1'b0, 1'b0, 1'b0, 1'b1});
      chk("a_stored", 8'h5A, oa);
      fb = 8'h22;
      // stored word and port a must change on the same edge
      cb = 1'b1;
      gap(3);
      chk("b_word_now", 8'h22, qb);
      chk("a_fresh", 8'h22, oa);
      cb = 1'b0;
      gap(6);
      fb = 8'h33;
      gap(5);
      chk("a_hold", 8'h22, oa);
      $display("test a drives done");
   endtask
   task automatic t_b_drives;
      set('{1'b0, 1'b1, 1'b0, 1'b1});
      chk("b_oe", 8'hFF, boe);
      chk("a_oe", 8'h00, aoe);
      fa = 8'h77;
      gap(5);
      chk("b_live", 8'h77, ob);
      chk("a_word", 8'h3C, qa);
      set('{1'b0, 1'b1, 1'b1, 1'b1});
      chk("b_stored", 8'h3C, ob);
      fa = 8'h99;
      pulse(1'b0);
      chk("b_fresh", 8'h99, ob);
      chk("a_word", 8'h99, qa);
      $display("test b drives done");
   endtask
   task automatic t_disable_again;
      set('{1'b1, 1'b1, 1'b1, 1'b1});
      chk("a_oe", 8'h00, aoe);
      chk("b_oe", 8'h00, boe);
      chk("a_word", 8'h99, qa);
      chk("b_word", 8'h22, qb);
      $display("test disable again done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      gap(5);
      rst = 1'b0;
      t_after_reset();
      t_disabled();
      t_a_drives();
      t_b_drives();
      t_disable_again();
      print_verdict();
   end
   // the run needs about 500 ns; the limit leaves a wide margin
   initial begin
      #5000;
      bad_count++;
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
